// ---- rtl/mstr_translator.sv ----
// Function
// - Resolution codes 000..100 select 1/32, 1/16, 1/8, 1/4, 1/2 circular stepping.
// - Each position maps to the tabulated signed coil x and coil y currents.
// - Each active step edge moves the position one step in the selected direction.
// - Stepping continues even while the motor output enable bit is zero.
// - A polarity bit chooses rising or falling step edge as the trigger.
// - Direction is the pin combined with the programmed direction bit.
// - The 7-bit position in 1/32 units is readable in the position status register.
// - The readable position changes right after each accepted step.
// - A new resolution leaves the position alone until the next step pulse.
// - On a finer resolution currents go to the nearest point of the finer grid.
// - Coarser resolution on a shared position continues along the table without offset.
// - Coarser resolution off the new grid steps coarsely, keeping a constant offset.
// - With unchanged resolution each step moves the index by exactly one.
// - Codes 101 and 110 use the square table at full magnitude.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
module mstr_translator
  import mstr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clken,
  input wire logic step_pulse,
  input wire logic direction_pin,
  input wire logic [3:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  output logic [mstr_pkg::MSTR_POS_W-1:0] translator_position,
  output logic signed [mstr_pkg::MSTR_CUR_W-1:0] coil_x,
  output logic signed [mstr_pkg::MSTR_CUR_W-1:0] coil_y,
  output logic motor_output_enable
);

  import mstr_pkg::*;

  // Increment in 1/32 units for a resolution code; the spare code steps like 1/32.
  function automatic logic [MSTR_POS_W-1:0] step_size(input mstr_res_t res);
    case (res)
      MSTR_RES_32: step_size = 7'h01;
      MSTR_RES_16: step_size = 7'h02;
      MSTR_RES_8: step_size = 7'h04;
      MSTR_RES_4: step_size = 7'h08;
      MSTR_RES_2: step_size = 7'h10;
      MSTR_RES_HALF_SQ: step_size = 7'h10;
      MSTR_RES_FULL: step_size = 7'h20;
      default: step_size = 7'h01;
    endcase
  endfunction

  // Control register and its decoded fields.
  logic [MSTR_CTRL_W-1:0] ctrl_ff;
  logic [MSTR_CTRL_W-1:0] nxt_ctrl;
  mstr_res_t step_resolution;
  logic direction_control_bit;
  logic step_edge_polarity;

  // Stepping state.
  logic [MSTR_POS_W-1:0] pos_ff;
  logic [MSTR_POS_W-1:0] nxt_pos;
  mstr_res_t applied_ff;
  mstr_res_t nxt_applied;
  logic signed [MSTR_CUR_W-1:0] coil_x_ff;
  logic signed [MSTR_CUR_W-1:0] coil_y_ff;
  logic signed [MSTR_CUR_W-1:0] tab_x;
  logic signed [MSTR_CUR_W-1:0] tab_y;
  logic step_fire;
  logic reverse;
  logic [MSTR_POS_W-1:0] inc;
  logic [MSTR_POS_W-1:0] base;

  // Bus channel state.
  logic aw_full_ff;
  logic nxt_aw_full;
  logic w_full_ff;
  logic nxt_w_full;
  logic [3:0] awaddr_ff;
  logic [3:0] nxt_awaddr;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [3:0] wstrb_ff;
  logic [3:0] nxt_wstrb;
  logic awready_ff;
  logic nxt_awready;
  logic wready_ff;
  logic nxt_wready;
  logic bvalid_ff;
  logic nxt_bvalid;
  logic [1:0] bresp_ff;
  logic [1:0] nxt_bresp;
  logic arready_ff;
  logic nxt_arready;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] rresp_ff;
  logic [1:0] nxt_rresp;

  assign step_resolution = mstr_res_t'(ctrl_ff[MSTR_CTRL_RES_LSB +: 3]);
  assign direction_control_bit = ctrl_ff[MSTR_CTRL_DIR_BIT];
  assign step_edge_polarity = ctrl_ff[MSTR_CTRL_POL_BIT];

  // The step input is taken as synchronous; the detector only reports the chosen edge.
  mstr_step_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .clken(clken),
    .step_pulse(step_pulse),
    .step_edge_polarity(step_edge_polarity),
    .step_fire(step_fire)
  );

  // Current lookup follows the resolution that was last applied by a step, not the one just written.
  mstr_coil_table u_table (
    .position(pos_ff),
    .square((applied_ff == MSTR_RES_HALF_SQ) || (applied_ff == MSTR_RES_FULL)),
    .coil_x(tab_x),
    .coil_y(tab_y)
  );

  // Position update; the enable bit is deliberately not looked at, so the counter runs with bridges off.
  always_comb begin
    reverse = direction_pin ^ direction_control_bit;
    inc = step_size(step_resolution);
    base = pos_ff;
    nxt_pos = pos_ff;
    nxt_applied = applied_ff;
    if (step_fire) begin
      if (inc < step_size(applied_ff)) begin
        // Finer grid: round to its nearest point before moving on it.
        base = (pos_ff + (inc >> 1)) & ~(inc - 7'h01);
      end
      // A coarser or equal grid moves from where it stands; an off-grid spot keeps its offset.
      if (reverse) begin
        nxt_pos = base - inc;
      end else begin
        nxt_pos = base + inc;
      end
      nxt_applied = step_resolution;
    end
  end

  // Stepping registers; coil outputs follow the position one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_ff <= MSTR_POS_RESET;
      applied_ff <= MSTR_RES_32;
      coil_x_ff <= '0;
      coil_y_ff <= '0;
    end else if (clken) begin
      pos_ff <= nxt_pos;
      applied_ff <= nxt_applied;
      coil_x_ff <= tab_x;
      coil_y_ff <= tab_y;
    end
  end

  // Write channel: address and data are caught independently, committed together, then answered.
  always_comb begin
    nxt_aw_full = aw_full_ff;
    nxt_w_full = w_full_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    if (bvalid_ff && s_axil_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axil_awvalid && awready_ff) begin
      nxt_aw_full = 1'b1;
      nxt_awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && wready_ff) begin
      nxt_w_full = 1'b1;
      nxt_wdata = s_axil_wdata;
      nxt_wstrb = s_axil_wstrb;
    end
    if (aw_full_ff && w_full_ff && !bvalid_ff) begin
      nxt_aw_full = 1'b0;
      nxt_w_full = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = MSTR_RESP_OKAY;
      case (awaddr_ff[3:2])
        MSTR_ADDR_CTRL[3:2]: begin
          if (wstrb_ff[0]) begin
            nxt_ctrl = wdata_ff[MSTR_CTRL_W-1:0];
          end
        end
        MSTR_ADDR_POS[3:2], MSTR_ADDR_COIL[3:2]: begin
          nxt_bresp = MSTR_RESP_OKAY;
        end
        default: begin
          nxt_bresp = MSTR_RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = ~nxt_aw_full;
    nxt_wready = ~nxt_w_full;
  end

  // Write channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= MSTR_RESP_OKAY;
      ctrl_ff <= MSTR_CTRL_RESET;
    end else if (clken) begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff <= nxt_w_full;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Read channel: one read at a time, data sampled when the address is taken.
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && s_axil_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axil_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = 32'h0000_0000;
      nxt_rresp = MSTR_RESP_OKAY;
      case (s_axil_araddr[3:2])
        MSTR_ADDR_CTRL[3:2]: begin
          nxt_rdata[MSTR_CTRL_W-1:0] = ctrl_ff;
        end
        MSTR_ADDR_POS[3:2]: begin
          nxt_rdata[MSTR_POS_LSB +: MSTR_POS_W] = pos_ff;
          nxt_rdata[MSTR_APPLIED_LSB +: 3] = applied_ff;
        end
        MSTR_ADDR_COIL[3:2]: begin
          nxt_rdata[MSTR_COIL_X_LSB +: MSTR_CUR_W] = coil_x_ff;
          nxt_rdata[MSTR_COIL_Y_LSB +: MSTR_CUR_W] = coil_y_ff;
        end
        default: begin
          nxt_rresp = MSTR_RESP_SLVERR;
        end
      endcase
    end
    nxt_arready = ~nxt_rvalid;
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= MSTR_RESP_OKAY;
    end else if (clken) begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // Outputs come straight from registers.
  assign s_axil_awready = awready_ff;
  assign s_axil_wready = wready_ff;
  assign s_axil_bvalid = bvalid_ff;
  assign s_axil_bresp = bresp_ff;
  assign s_axil_arready = arready_ff;
  assign s_axil_rvalid = rvalid_ff;
  assign s_axil_rdata = rdata_ff;
  assign s_axil_rresp = rresp_ff;
  assign translator_position = pos_ff;
  assign coil_x = coil_x_ff;
  assign coil_y = coil_y_ff;
  assign motor_output_enable = ctrl_ff[MSTR_CTRL_MOTOR_OUTPUT_ENABLE_BIT];

endmodule

// ---- rtl/mstr_pkg.sv ----
package mstr_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] MSTR_ADDR_CTRL = 4'h0;
  localparam logic [3:0] MSTR_ADDR_POS = 4'h4;
  localparam logic [3:0] MSTR_ADDR_COIL = 4'h8;

  // Control register field positions and value after reset.
  localparam int MSTR_CTRL_W = 6;
  localparam int MSTR_CTRL_RES_LSB = 0;
  localparam int MSTR_CTRL_DIR_BIT = 3;
  localparam int MSTR_CTRL_POL_BIT = 4;
  localparam int MSTR_CTRL_MOTOR_OUTPUT_ENABLE_BIT = 5;
  localparam logic [5:0] MSTR_CTRL_RESET = 6'h00;

  // Position status register field positions.
  localparam int MSTR_POS_LSB = 0;
  localparam int MSTR_APPLIED_LSB = 8;

  // Coil register field positions.
  localparam int MSTR_COIL_X_LSB = 0;
  localparam int MSTR_COIL_Y_LSB = 16;

  // Position counter width and coil current width in tenths of a percent.
  localparam int MSTR_POS_W = 7;
  localparam int MSTR_CUR_W = 12;
  localparam logic [6:0] MSTR_POS_RESET = 7'h00;

  // Bus answers.
  localparam logic [1:0] MSTR_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSTR_RESP_SLVERR = 2'h2;

  // Step resolution codes.
  typedef enum logic [2:0] {
    MSTR_RES_32 = 3'b000,
    MSTR_RES_16 = 3'b001,
    MSTR_RES_8 = 3'b010,
    MSTR_RES_4 = 3'b011,
    MSTR_RES_2 = 3'b100,
    MSTR_RES_HALF_SQ = 3'b101,
    MSTR_RES_FULL = 3'b110,
    MSTR_RES_SPARE = 3'b111
  } mstr_res_t;

endpackage

// ---- rtl/mstr_step_edge.sv ----
module mstr_step_edge
  import mstr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clken,
  input wire logic step_pulse,
  input wire logic step_edge_polarity,
  output logic step_fire
);

  logic prev_ff;
  logic primed_ff;
  logic nxt_prev;
  logic nxt_primed;

  // The first enabled cycle after reset only samples the pin, so a pin that is already high gives no step.
  always_comb begin
    nxt_prev = step_pulse;
    nxt_primed = 1'b1;
    if (step_edge_polarity) begin
      step_fire = primed_ff & prev_ff & ~step_pulse;
    end else begin
      step_fire = primed_ff & ~prev_ff & step_pulse;
    end
    if (!clken) begin
      step_fire = 1'b0;
    end
  end

  // Edge history registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_ff <= 1'b0;
      primed_ff <= 1'b0;
    end else if (clken) begin
      prev_ff <= nxt_prev;
      primed_ff <= nxt_primed;
    end
  end

endmodule

// ---- rtl/mstr_coil_table.sv ----
module mstr_coil_table
  import mstr_pkg::*;
(
  input wire logic [MSTR_POS_W-1:0] position,
  input wire logic square,
  output logic signed [MSTR_CUR_W-1:0] coil_x,
  output logic signed [MSTR_CUR_W-1:0] coil_y
);

  // Quarter wave of the circle in tenths of a percent; the other quadrants are mirrored from it.
  localparam logic [MSTR_CUR_W-1:0] SINE [0:32] = '{
    12'h000, 12'h023, 12'h051, 12'h07F, 12'h0AE, 12'h0DD, 12'h10B, 12'h13A,
    12'h15D, 12'h17F, 12'h1AE, 12'h1D1, 12'h1F4, 12'h222, 12'h245, 12'h268,
    12'h28B, 12'h2AE, 12'h2D1, 12'h2F3, 12'h316, 12'h33A, 12'h351, 12'h368,
    12'h37F, 12'h396, 12'h3A2, 12'h3AD, 12'h3B9, 12'h3C5, 12'h3D1, 12'h3DC,
    12'h3E8
  };
  localparam logic [MSTR_CUR_W-1:0] FULL_SCALE = 12'h3E8;

  logic [5:0] rise;
  logic [5:0] fall;
  logic [MSTR_CUR_W-1:0] a;
  logic [MSTR_CUR_W-1:0] b;

  // Quadrant folding for the circle, octant lookup for the square.
  always_comb begin
    rise = {1'b0, position[4:0]};
    fall = 6'h20 - rise;
    a = SINE[rise];
    b = SINE[fall];
    coil_x = '0;
    coil_y = '0;
    if (square) begin
      case (position[6:4])
        3'h0: begin coil_x = '0; coil_y = FULL_SCALE; end
        3'h1: begin coil_x = FULL_SCALE; coil_y = FULL_SCALE; end
        3'h2: begin coil_x = FULL_SCALE; coil_y = '0; end
        3'h3: begin coil_x = FULL_SCALE; coil_y = -FULL_SCALE; end
        3'h4: begin coil_x = '0; coil_y = -FULL_SCALE; end
        3'h5: begin coil_x = -FULL_SCALE; coil_y = -FULL_SCALE; end
        3'h6: begin coil_x = -FULL_SCALE; coil_y = '0; end
        default: begin coil_x = -FULL_SCALE; coil_y = FULL_SCALE; end
      endcase
    end else begin
      case (position[6:5])
        2'h0: begin coil_x = a; coil_y = b; end
        2'h1: begin coil_x = b; coil_y = -a; end
        2'h2: begin coil_x = -a; coil_y = -b; end
        default: begin coil_x = -b; coil_y = a; end
      endcase
    end
  end

endmodule

// ---- sim/mstr_translator_asserts.sv ----
module mstr_translator_asserts
  import mstr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clken,
  input wire logic step_pulse,
  input wire logic [mstr_pkg::MSTR_POS_W-1:0] translator_position,
  input wire logic signed [mstr_pkg::MSTR_CUR_W-1:0] coil_x,
  input wire logic signed [mstr_pkg::MSTR_CUR_W-1:0] coil_y,
  input wire logic [3:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp,
  input wire logic s_axil_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clocking and disable are stated once.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !clken);

  // Without a new step level the position must hold; a level that changed while frozen fires on resume.
  AST_POS_HOLD: assert property ($past(aresetn, 2) && $past(clken) && step_pulse == $past(step_pulse) |=>
    $stable(translator_position)) else $error("position moved without a step edge");
  // Coil outputs follow the position one edge later, so a held position means held currents.
  AST_COIL_HOLD: assert property ($past(aresetn, 2) && $past(aresetn) && $stable(translator_position) |=>
    $stable(coil_x) && $stable(coil_y)) else $error("coil changed while position held");
  // The cardinal points agree in the circular and the square table, so they hold in every mode.
  AST_COIL_EAST: assert property ($past(aresetn) && $past(translator_position) == 7'h20 |->
    coil_x == 12'h3E8 && coil_y == 12'h000) else $error("coil wrong at quarter turn");
  AST_COIL_SOUTH: assert property ($past(aresetn) && $past(translator_position) == 7'h40 |->
    coil_x == 12'h000 && coil_y == 12'hC18) else $error("coil wrong at half turn");
  AST_COIL_WEST: assert property ($past(aresetn) && $past(translator_position) == 7'h60 |->
    coil_x == 12'hC18 && coil_y == 12'h000) else $error("coil wrong at three quarter turn");
  // A position read returns the value standing when the address was taken, even if a step lands then.
  AST_POS_READ: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr == MSTR_ADDR_POS |=>
    s_axil_rdata[6:0] == $past(translator_position) && s_axil_rresp == MSTR_RESP_OKAY)
    else $error("stale position read");
  AST_RD_LATENCY: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer late");
  AST_RD_UNMAPPED: assert property (s_axil_arvalid && s_axil_arready && s_axil_araddr == 4'hC |=>
    s_axil_rresp == MSTR_RESP_SLVERR && s_axil_rdata == 32'h0) else $error("unmapped read not refused");
  AST_AR_BLOCKED: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("address accepted while answer pending");
endmodule

// ---- sim/mstr_mcu_model.sv ----
module mstr_mcu_model (
  output logic step_pulse,
  output logic direction_pin,
  input wire logic aclk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines park low, as a controller does before its first move.
  initial begin
    step_pulse = 1'h0;
    direction_pin = 1'h0;
  end
  // Direction settles a cycle before the step edge so it is never caught mid-change.
  task automatic set_dir(input logic d);
    @(posedge aclk);
    direction_pin <= d;
  endtask
  // Each level stands at least three cycles, above the one-cycle minimum, so no edge is lost.
  task automatic level(input logic v);
    @(posedge aclk);
    step_pulse <= v;
    repeat (2) @(posedge aclk);
  endtask
endmodule

// ---- sim/mstr_translator_tb.sv ----
module mstr_translator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mstr_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic step_pulse, direction_pin, s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_arvalid = 1'h0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid, motor_output_enable;
  logic [3:0] s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [MSTR_POS_W-1:0] translator_position;
  logic signed [MSTR_CUR_W-1:0] coil_x, coil_y;
  logic clken = 1'h1, s_axil_bready = 1'h0, s_axil_rready = 1'h0;
  logic [5:0] ctrl = 6'h00;
  logic [6:0] pos = 7'h00;
  logic [2:0] appl = 3'h0;
  int n_fail = 0, n_checks = 0, cyc = 0;
  // Each entry is {pin, ctrl}: all eight codes, then direction, wrap, and the grid changes.
  // Codes 01 at 0x02, 06 at 0x20 and 04 at 0x50 are lowered on a shared grid point; the rest show the offset.
  logic [6:0] plan [29] = '{7'h00, 7'h00, 7'h01, 7'h01, 7'h02, 7'h12, 7'h03, 7'h23, 7'h04, 7'h04,
    7'h05, 7'h35, 7'h06, 7'h06, 7'h07, 7'h07, 7'h00, 7'h40, 7'h08, 7'h48, 7'h46, 7'h56, 7'h46,
    7'h00, 7'h00, 7'h20, 7'h03, 7'h02, 7'h04};

  always #2 aclk = ~aclk;

  // All byte strobes stay high; only byte 0 carries control bits, so partial writes add nothing here.
  mstr_translator i_dut (.aclk(aclk), .aresetn(aresetn), .clken(clken), .step_pulse(step_pulse),
    .direction_pin(direction_pin), .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata), .s_axil_wstrb(4'hF),
    .s_axil_wvalid(s_axil_wvalid), .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
    .translator_position(translator_position), .coil_x(coil_x), .coil_y(coil_y),
    .motor_output_enable(motor_output_enable));
  mstr_mcu_model i_mcu (.step_pulse(step_pulse), .direction_pin(direction_pin), .aclk(aclk));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Address and data are offered together and each is dropped at its own take.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axil_awready) begin
        aw_ok = 1'h1;
        s_axil_awvalid <= 1'h0;
      end
      if (!w_ok && s_axil_wready) begin
        w_ok = 1'h1;
        s_axil_wvalid <= 1'h0;
      end
    end
    s_axil_bready <= 1'h1;
    do @(posedge aclk); while (!s_axil_bvalid);
    r = s_axil_bresp;
    s_axil_bready <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axil_arready);
    s_axil_arvalid <= 1'h0;
    s_axil_rready <= 1'h1;
    do @(posedge aclk); while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'h0;
  endtask

  function automatic logic [6:0] sz(input logic [2:0] r);
    case (r)
      3'h5: return 7'h10;
      3'h6: return 7'h20;
      3'h7: return 7'h01;
      default: return 7'h01 << r;
    endcase
  endfunction

  // A finer code first snaps to the nearest finer grid point; a coarser one keeps the offset.
  function automatic logic [6:0] nxt(input logic [6:0] p, input logic [2:0] res, input logic [2:0] ap,
    input logic rev);
    logic [6:0] s;
    s = sz(res);
    if (s < sz(ap))
      p = (p + (s >> 1)) & ~(s - 7'h01);
    return rev ? p - s : p + s;
  endfunction

  // One full pulse; only the chosen edge may move the position, which wraps modulo 128.
  task automatic step1(input logic pin);
    logic [6:0] old;
    logic [31:0] d;
    logic [1:0] rs;
    old = pos;
    pos = nxt(pos, ctrl[2:0], appl, pin ^ ctrl[3]);
    appl = ctrl[2:0];
    i_mcu.set_dir(pin);
    i_mcu.level(1'h1);
    chk(32'(translator_position), 32'(ctrl[4] ? old : pos));
    i_mcu.level(1'h0);
    chk(32'(translator_position), 32'(pos));
    rd(MSTR_ADDR_POS, d, rs);
    chk(d, {21'h0, appl, 1'h0, pos});
  endtask

  // A hang is cut short well above the few hundred cycles the run needs.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    logic [31:0] exp_coil;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(MSTR_ADDR_CTRL, d, rs);
    chk(d, 32'(MSTR_CTRL_RESET));
    rd(MSTR_ADDR_POS, d, rs);
    chk(d, 32'h0);
    $display("test reset done");
    foreach (plan[i]) begin
      wr(MSTR_ADDR_CTRL, {26'h0, plan[i][5:0]}, rs);
      ctrl = plan[i][5:0];
      chk(32'(translator_position), 32'(pos));
      chk(32'(motor_output_enable), 32'(ctrl[5]));
      step1(plan[i][6]);
      if (i == 10 || i == 12 || i == 15) begin
        rd(MSTR_ADDR_COIL, d, rs);
        exp_coil = (i == 10) ? 32'h0C18_0000 : (i == 12) ? 32'h03E8_0C18 : 32'h0000_03E8;
        chk(d, exp_coil);
        chk({4'h0, coil_y, 4'h0, coil_x}, exp_coil);
      end
    end
    // A rising step while the enable is low must wait; it fires on the first enabled edge.
    clken <= 1'h0;
    i_mcu.level(1'h1);
    chk(32'(translator_position), 32'(pos));
    clken <= 1'h1;
    pos = nxt(pos, ctrl[2:0], appl, 1'h0);
    i_mcu.level(1'h0);
    chk(32'(translator_position), 32'(pos));
    $display("test stepping done");
    rd(4'hC, d, rs);
    chk(32'(rs), 32'(MSTR_RESP_SLVERR));
    chk(d, 32'h0);
    wr(4'hC, 32'h0, rs);
    chk(32'(rs), 32'(MSTR_RESP_SLVERR));
    wr(MSTR_ADDR_POS, 32'h0000_007F, rs);
    chk(32'(rs), 32'(MSTR_RESP_OKAY));
    rd(MSTR_ADDR_POS, d, rs);
    chk(d, {21'h0, appl, 1'h0, pos});
    rd(MSTR_ADDR_CTRL, d, rs);
    chk(d, {26'h0, ctrl});
    $display("test bus done");
    report_and_stop();
  end
endmodule

bind mstr_translator mstr_translator_asserts i_chk (.aclk(aclk), .aresetn(aresetn), .clken(clken),
  .step_pulse(step_pulse), .translator_position(translator_position), .coil_x(coil_x), .coil_y(coil_y),
  .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid));
